// [design/rrs_alu.sv]
// Rotate-through-carry and subtract-with-borrow arithmetic with flag results
`timescale 1ns/1ps
`default_nettype none
module rrs_alu
(
  // Operation and operands
  input wire rrs_pkg::rrs_op_t i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_opnd,
  input wire logic i_carry,
  // Result and flags
  output logic [7:0] o_res,
  output logic o_v,
  output logic o_n,
  output logic o_z,
  output logic o_c
);
  import rrs_pkg::*;
  logic [8:0] diff;
  logic sbc_v;

  // Nine-bit difference keeps the borrow in the top bit
  assign diff = {1'b0, i_acc} - {1'b0, i_opnd} - {8'h00, i_carry};
  assign sbc_v = (i_acc[7] & ~i_opnd[7] & ~diff[7]) | (~i_acc[7] & i_opnd[7] & diff[7]);

  // Result and flag selection
  always_comb
  begin
    case (i_op)
      OP_ROL:
      begin
        o_res = {i_opnd[6:0], i_carry};
        o_c = i_opnd[7];
      end
      OP_ROR:
      begin
        o_res = {i_carry, i_opnd[7:1]};
        o_c = i_opnd[0];
      end
      default:
      begin
        o_res = diff[7:0];
        o_c = diff[8];
      end
    endcase
    o_n = o_res[7];
    o_z = (o_res == 8'h00);
    o_v = (i_op == OP_SBC) ? sbc_v : (o_n ^ o_c);
  end
endmodule // rrs_alu
`default_nettype wire

// [design/rrs_decode.sv]
// Opcode decoder: operation, operand source and cycle count
`timescale 1ns/1ps
`default_nettype none
module rrs_decode
(
  // Opcode with optional prebyte in the high byte
  input wire logic [15:0] i_opcode,
  // Decoded instruction
  output rrs_pkg::rrs_op_t o_op,
  output rrs_pkg::rrs_tgt_t o_tgt,
  output logic [2:0] o_cycles
);
  import rrs_pkg::*;

  // One entry per documented opcode
  always_comb
  begin
    o_op = OP_BAD;
    o_tgt = TGT_NONE;
    o_cycles = CYC_RMW_REG;
    case (i_opcode)
      OPC_ROL_DIR: begin o_op = OP_ROL; o_tgt = TGT_MEM; o_cycles = CYC_RMW_DIR; end
      OPC_ROL_ACC: begin o_op = OP_ROL; o_tgt = TGT_ACC; o_cycles = CYC_RMW_REG; end
      OPC_ROL_IDX: begin o_op = OP_ROL; o_tgt = TGT_IDX; o_cycles = CYC_RMW_REG; end
      OPC_ROL_IX1: begin o_op = OP_ROL; o_tgt = TGT_MEM; o_cycles = CYC_RMW_IX1; end
      OPC_ROL_IX: begin o_op = OP_ROL; o_tgt = TGT_MEM; o_cycles = CYC_RMW_IX; end
      OPC_ROL_SP1: begin o_op = OP_ROL; o_tgt = TGT_MEM; o_cycles = CYC_RMW_SP1; end
      OPC_ROR_DIR: begin o_op = OP_ROR; o_tgt = TGT_MEM; o_cycles = CYC_RMW_DIR; end
      OPC_ROR_ACC: begin o_op = OP_ROR; o_tgt = TGT_ACC; o_cycles = CYC_RMW_REG; end
      OPC_ROR_IDX: begin o_op = OP_ROR; o_tgt = TGT_IDX; o_cycles = CYC_RMW_REG; end
      OPC_ROR_IX1: begin o_op = OP_ROR; o_tgt = TGT_MEM; o_cycles = CYC_RMW_IX1; end
      OPC_ROR_IX: begin o_op = OP_ROR; o_tgt = TGT_MEM; o_cycles = CYC_RMW_IX; end
      OPC_ROR_SP1: begin o_op = OP_ROR; o_tgt = TGT_MEM; o_cycles = CYC_RMW_SP1; end
      OPC_SP_INIT: begin o_op = OP_SPI; o_cycles = CYC_SP_INIT; end
      OPC_INT_RET: begin o_op = OP_RTI; o_cycles = CYC_INT_RET; end
      OPC_SUB_RET: begin o_op = OP_RTS; o_cycles = CYC_SUB_RET; end
      OPC_SBC_IMM: begin o_op = OP_SBC; o_tgt = TGT_IMM; o_cycles = CYC_SBC_IMM; end
      OPC_SBC_DIR: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_DIR; end
      OPC_SBC_EXT: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_EXT; end
      OPC_SBC_IX2: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_IX2; end
      OPC_SBC_IX1: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_IX1; end
      OPC_SBC_IX: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_IX; end
      OPC_SBC_SP2: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_SP2; end
      OPC_SBC_SP1: begin o_op = OP_SBC; o_tgt = TGT_MEM; o_cycles = CYC_SBC_SP1; end
      default: o_op = OP_BAD;
    endcase
  end
endmodule // rrs_decode
`default_nettype wire

// [design/rrs_exec.sv]
// Execution unit for rotates, stack pointer init, returns and subtract with borrow
// Functional notes
// - Rotate left shifts toward MSB, bit 0 takes the prior carry.
// - Rotate left carry takes the operand MSB from before the rotate.
// - After either rotate, overflow is new negative XOR new carry.
// - Rotates and subtract: negative is result bit 7, zero when result is 00.
// - Rotate right shifts toward LSB, bit 7 takes the prior carry.
// - Rotate right carry takes the operand LSB from before the shift.
// - Rotate right opcodes 36,46,56,66,76,9E66 with cycles 4,1,1,4,3,5.
// - Interrupt return pulls flags, acc, index, PC high, PC low, pre-incrementing.
// - Interrupt return loads every flag, mask included, from the pulled byte.
// - Opcode 80 is interrupt return, implied operand mode, 7 cycles.
// - Subroutine return pulls PC high then low, pre-incrementing; no flags change.
// - Opcode 81 is subroutine return, implied operand mode, 4 cycles.
// - Subtract with borrow: acc minus operand minus carry, back into acc.
// - Subtract overflow on signed sign-mismatch between operands and result.
// - Subtract borrow set when operand plus carry exceeds acc unsigned.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module rrs_exec
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Program and stack memory, read data valid in the cycle of the request
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_rd,
  input wire logic [7:0] i_mem_rdata,
  // Execution state
  output logic o_busy
);
  import rrs_pkg::*;

  rrs_state_t state_q;
  rrs_op_t op_q;
  rrs_tgt_t tgt_q;
  rrs_op_t dec_op;
  rrs_tgt_t dec_tgt;
  logic [2:0] dec_cycles;
  logic [2:0] cyc_q;
  logic [2:0] step_q;
  logic [15:0] opc_q;
  logic [7:0] acc_q;
  logic [7:0] idx_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic [15:0] ea_q;
  logic bad_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [15:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic mem_we_q;
  logic mem_rd_q;

  // Lane-aware update of a narrow register from a bus write
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    lane_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Bus decode: a transfer takes effect at the edge where ack is high
  wire bus_req = i_wb_cyc & i_wb_stb;
  wire wr_take = bus_req & i_wb_we & ack_q;
  wire busy = (state_q == S_EXEC);
  wire wr_ok = wr_take & ~busy;
  wire wr_opc = wr_take & (i_wb_adr == REG_OPCODE);
  wire [15:0] opc_new = lane_merge(opc_q, i_wb_dat, i_wb_sel);
  // Lane-merged write values for the byte-wide registers, low byte used
  wire [15:0] acc_wr = lane_merge({8'h00, acc_q}, i_wb_dat, i_wb_sel);
  wire [15:0] idx_wr = lane_merge({8'h00, idx_q}, i_wb_dat, i_wb_sel);
  wire [15:0] flags_wr = lane_merge({8'h00, flags_q}, i_wb_dat, i_wb_sel);
  wire start = wr_opc & ~busy & (dec_op != OP_BAD);
  wire rejected = wr_opc & ~busy & (dec_op == OP_BAD);

  // Read multiplexer, unmapped offsets read as zero
  wire [15:0] status_word = {5'h00, cyc_q, 6'h00, bad_q, busy};
  wire [31:0] rd_mux =
    (i_wb_adr == REG_OPCODE) ? {16'h0000, opc_q} :
    (i_wb_adr == REG_ACC) ? {24'h00_0000, acc_q} :
    (i_wb_adr == REG_INDEX) ? {24'h00_0000, idx_q} :
    (i_wb_adr == REG_SP) ? {16'h0000, sp_q} :
    (i_wb_adr == REG_PC) ? {16'h0000, pc_q} :
    (i_wb_adr == REG_FLAGS) ? {24'h00_0000, flags_q} :
    (i_wb_adr == REG_EA) ? {16'h0000, ea_q} :
    (i_wb_adr == REG_STATUS) ? {16'h0000, status_word} : 32'h0000_0000;

  // Opcode decoder looks at the value being written
  rrs_decode u_decode
  (
    .i_opcode(opc_new),
    .o_op(dec_op),
    .o_tgt(dec_tgt),
    .o_cycles(dec_cycles)
  );

  // Sequencer step decode
  wire last_step = (step_q == (cyc_q - 3'h1));
  wire is_rot = (op_q == OP_ROL) | (op_q == OP_ROR);
  wire is_pull = (op_q == OP_RTI) | (op_q == OP_RTS);
  wire [2:0] pulls = (op_q == OP_RTI) ? PULLS_INT_RET : PULLS_SUB_RET;
  wire [2:0] pull_base = (op_q == OP_RTI) ? 3'h0 : PULL_BASE_SUB;
  wire issue_pull = busy & is_pull & (step_q < pulls);
  wire load_pull = busy & is_pull & (step_q != 3'h0) & (step_q <= pulls);
  wire [2:0] load_idx = pull_base + step_q - 3'h1;
  wire opnd_read = busy & (tgt_q == TGT_MEM) & (step_q == 3'h0);
  wire alu_en = busy & (is_rot | (op_q == OP_SBC)) &
                (((tgt_q != TGT_MEM) & (step_q == 3'h0)) | ((tgt_q == TGT_MEM) & (step_q == 3'h1)));
  wire spi_en = busy & (op_q == OP_SPI) & (step_q == 3'h0);
  wire [15:0] sp_next = sp_q + 16'h0001;

  // Operand selection for the arithmetic unit
  wire [7:0] alu_opnd =
    (tgt_q == TGT_MEM) ? i_mem_rdata :
    (tgt_q == TGT_IMM) ? ea_q[7:0] :
    (tgt_q == TGT_IDX) ? idx_q : acc_q;
  logic [7:0] alu_res;
  logic alu_v;
  logic alu_n;
  logic alu_z;
  logic alu_c;

  // Arithmetic unit
  rrs_alu u_alu
  (
    .i_op(op_q),
    .i_acc(acc_q),
    .i_opnd(alu_opnd),
    .i_carry(flags_q[FLG_C]),
    .o_res(alu_res),
    .o_v(alu_v),
    .o_n(alu_n),
    .o_z(alu_z),
    .o_c(alu_c)
  );

  // Result routing
  wire acc_from_alu = alu_en & ((op_q == OP_SBC) | (tgt_q == TGT_ACC));
  wire idx_from_alu = alu_en & is_rot & (tgt_q == TGT_IDX);
  wire mem_from_alu = alu_en & is_rot & (tgt_q == TGT_MEM);

  // Bus ack is a one-cycle pulse one cycle after the strobe
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_req & ~ack_q;
      dat_q <= rd_mux;
    end
  end

  // Sequencer: idle until an opcode is taken, then one step per cycle
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_q <= S_IDLE;
      step_q <= 3'h0;
      cyc_q <= 3'h0;
      op_q <= OP_BAD;
      tgt_q <= TGT_NONE;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          step_q <= 3'h0;
          if (start)
          begin
            state_q <= S_EXEC;
            op_q <= dec_op;
            tgt_q <= dec_tgt;
            cyc_q <= dec_cycles;
          end
        end
        S_EXEC:
        begin
          step_q <= step_q + 3'h1;
          if (last_step)
            state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Opcode register and bad-opcode flag, a good opcode clears it
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      opc_q <= 16'h0000;
      bad_q <= 1'b0;
    end
    else if (wr_opc & ~busy)
    begin
      opc_q <= opc_new;
      bad_q <= rejected;
    end
  end

  // Accumulator and index low byte
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      acc_q <= 8'h00;
      idx_q <= 8'h00;
    end
    else
    begin
      if (acc_from_alu)
        acc_q <= alu_res;
      else if (load_pull & (load_idx == 3'h1))
        acc_q <= i_mem_rdata;
      else if (wr_ok & (i_wb_adr == REG_ACC))
        acc_q <= acc_wr[7:0];
      if (idx_from_alu)
        idx_q <= alu_res;
      else if (load_pull & (load_idx == 3'h2))
        idx_q <= i_mem_rdata;
      else if (wr_ok & (i_wb_adr == REG_INDEX))
        idx_q <= idx_wr[7:0];
    end
  end

  // Stack pointer: pre-increment on each pull, fixed load on init
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      sp_q <= SP_RESET;
    else if (spi_en)
      sp_q <= SP_INIT;
    else if (issue_pull)
      sp_q <= sp_next;
    else if (wr_ok & (i_wb_adr == REG_SP))
      sp_q <= lane_merge(sp_q, i_wb_dat, i_wb_sel);
  end

  // Program counter, high byte then low byte from the stack
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      pc_q <= 16'h0000;
    else if (load_pull & (load_idx == 3'h3))
      pc_q <= {i_mem_rdata, pc_q[7:0]};
    else if (load_pull & (load_idx == 3'h4))
      pc_q <= {pc_q[15:8], i_mem_rdata};
    else if (wr_ok & (i_wb_adr == REG_PC))
      pc_q <= lane_merge(pc_q, i_wb_dat, i_wb_sel);
  end

  // Flags: arithmetic touches V N Z C only, interrupt return loads all
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      flags_q <= FLAGS_RESET;
    else if (alu_en)
    begin
      flags_q[FLG_V] <= alu_v;
      flags_q[FLG_N] <= alu_n;
      flags_q[FLG_Z] <= alu_z;
      flags_q[FLG_C] <= alu_c;
    end
    else if (load_pull & (load_idx == 3'h0))
      flags_q <= i_mem_rdata | FLAGS_ONES;
    else if (wr_ok & (i_wb_adr == REG_FLAGS))
      flags_q <= flags_wr[7:0] | FLAGS_ONES;
  end

  // Effective address, placed by software before the opcode
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      ea_q <= 16'h0000;
    else if (wr_ok & (i_wb_adr == REG_EA))
      ea_q <= lane_merge(ea_q, i_wb_dat, i_wb_sel);
  end

  // Memory request registers
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 8'h00;
      mem_we_q <= 1'b0;
      mem_rd_q <= 1'b0;
    end
    else
    begin
      mem_rd_q <= issue_pull | opnd_read;
      mem_we_q <= mem_from_alu;
      if (issue_pull)
        mem_addr_q <= sp_next;
      else if (opnd_read | mem_from_alu)
        mem_addr_q <= ea_q;
      if (mem_from_alu)
        mem_wdata_q <= alu_res;
    end
  end

  // Outputs
  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;
  assign o_mem_addr = mem_addr_q;
  assign o_mem_wdata = mem_wdata_q;
  assign o_mem_we = mem_we_q;
  assign o_mem_rd = mem_rd_q;
  assign o_busy = busy;

  // Checks
  rol_result_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en && op_q == OP_ROL && tgt_q == TGT_ACC |=>
      acc_q == {$past(acc_q[6:0]), $past(flags_q[FLG_C])}) else $error("rotate left result wrong");
  rol_carry_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en && op_q == OP_ROL |=> flags_q[FLG_C] == $past(alu_opnd[7]))
    else $error("rotate left carry wrong");
  rot_overflow_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en && is_rot |=> flags_q[FLG_V] == (flags_q[FLG_N] ^ flags_q[FLG_C]))
    else $error("rotate overflow wrong");
  zero_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en |=> flags_q[FLG_Z] == ($past(alu_res) == 8'h00) && flags_q[FLG_N] == $past(alu_res[7]))
    else $error("zero or negative flag wrong");
  ror_result_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en && op_q == OP_ROR && tgt_q == TGT_IDX |=>
      idx_q == {$past(flags_q[FLG_C]), $past(idx_q[7:1])}) else $error("rotate right result wrong");
  ror_carry_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en && op_q == OP_ROR |=> flags_q[FLG_C] == $past(alu_opnd[0]))
    else $error("rotate right carry wrong");
  sp_init_a: assert property (@(posedge i_clock) disable iff (i_rst)
    start && dec_op == OP_SPI |=> ##1 sp_q == SP_INIT && $stable(flags_q) && !busy)
    else $error("stack pointer init wrong");
  rti_flags_a: assert property (@(posedge i_clock) disable iff (i_rst)
    load_pull && load_idx == 3'h0 |=> flags_q == ($past(i_mem_rdata) | FLAGS_ONES))
    else $error("flags not restored");
  rti_length_a: assert property (@(posedge i_clock) disable iff (i_rst)
    start && dec_op == OP_RTI |=> busy [*7] ##1 !busy) else $error("interrupt return length");
  rts_length_a: assert property (@(posedge i_clock) disable iff (i_rst)
    start && dec_op == OP_RTS |=> busy [*4] ##1 !busy) else $error("subroutine return length");
  sbc_borrow_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en && op_q == OP_SBC |=> flags_q[FLG_C] ==
      (({1'b0, $past(alu_opnd)} + {8'h00, $past(flags_q[FLG_C])}) > {1'b0, $past(acc_q)}))
    else $error("subtract borrow wrong");
  mask_kept_a: assert property (@(posedge i_clock) disable iff (i_rst)
    alu_en |=> flags_q[FLG_H] == $past(flags_q[FLG_H]) && flags_q[FLG_I] == $past(flags_q[FLG_I]))
    else $error("half carry or mask changed");
endmodule // rrs_exec
`default_nettype wire

// [design/rrs_pkg.sv]
// Shared constants and types for the rotate, return and subtract execution unit
package rrs_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] REG_OPCODE = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_INDEX = 8'h08;
  localparam logic [7:0] REG_SP = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_FLAGS = 8'h14;
  localparam logic [7:0] REG_EA = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  // Flags register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  // Reset values and fixed loads
  localparam logic [15:0] SP_INIT = 16'h00FF;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] PREBYTE = 8'h9E;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_BAD = 1;
  localparam int ST_CYC_LSB = 8;
  // Opcodes, prebyte in the high byte or zero
  localparam logic [15:0] OPC_ROL_DIR = 16'h0039;
  localparam logic [15:0] OPC_ROL_ACC = 16'h0049;
  localparam logic [15:0] OPC_ROL_IDX = 16'h0059;
  localparam logic [15:0] OPC_ROL_IX1 = 16'h0069;
  localparam logic [15:0] OPC_ROL_IX = 16'h0079;
  localparam logic [15:0] OPC_ROL_SP1 = 16'h9E69;
  localparam logic [15:0] OPC_ROR_DIR = 16'h0036;
  localparam logic [15:0] OPC_ROR_ACC = 16'h0046;
  localparam logic [15:0] OPC_ROR_IDX = 16'h0056;
  localparam logic [15:0] OPC_ROR_IX1 = 16'h0066;
  localparam logic [15:0] OPC_ROR_IX = 16'h0076;
  localparam logic [15:0] OPC_ROR_SP1 = 16'h9E66;
  localparam logic [15:0] OPC_SP_INIT = 16'h009C;
  localparam logic [15:0] OPC_INT_RET = 16'h0080;
  localparam logic [15:0] OPC_SUB_RET = 16'h0081;
  localparam logic [15:0] OPC_SBC_IMM = 16'h00A2;
  localparam logic [15:0] OPC_SBC_DIR = 16'h00B2;
  localparam logic [15:0] OPC_SBC_EXT = 16'h00C2;
  localparam logic [15:0] OPC_SBC_IX2 = 16'h00D2;
  localparam logic [15:0] OPC_SBC_IX1 = 16'h00E2;
  localparam logic [15:0] OPC_SBC_IX = 16'h00F2;
  localparam logic [15:0] OPC_SBC_SP2 = 16'h9ED2;
  localparam logic [15:0] OPC_SBC_SP1 = 16'h9EE2;
  // Cycle counts per instruction form
  localparam logic [2:0] CYC_RMW_DIR = 3'h4;
  localparam logic [2:0] CYC_RMW_REG = 3'h1;
  localparam logic [2:0] CYC_RMW_IX1 = 3'h4;
  localparam logic [2:0] CYC_RMW_IX = 3'h3;
  localparam logic [2:0] CYC_RMW_SP1 = 3'h5;
  localparam logic [2:0] CYC_SP_INIT = 3'h1;
  localparam logic [2:0] CYC_INT_RET = 3'h7;
  localparam logic [2:0] CYC_SUB_RET = 3'h4;
  localparam logic [2:0] CYC_SBC_IMM = 3'h2;
  localparam logic [2:0] CYC_SBC_DIR = 3'h3;
  localparam logic [2:0] CYC_SBC_EXT = 3'h4;
  localparam logic [2:0] CYC_SBC_IX2 = 3'h4;
  localparam logic [2:0] CYC_SBC_IX1 = 3'h3;
  localparam logic [2:0] CYC_SBC_IX = 3'h2;
  localparam logic [2:0] CYC_SBC_SP2 = 3'h5;
  localparam logic [2:0] CYC_SBC_SP1 = 3'h4;
  // Stack pulls
  localparam logic [2:0] PULLS_INT_RET = 3'h5;
  localparam logic [2:0] PULLS_SUB_RET = 3'h2;
  localparam logic [2:0] PULL_BASE_SUB = 3'h3;
  // Operation, operand source and sequencer state
  typedef enum logic [2:0] {OP_ROL, OP_ROR, OP_SPI, OP_RTI, OP_RTS, OP_SBC, OP_BAD} rrs_op_t;
  typedef enum logic [2:0] {TGT_ACC, TGT_IDX, TGT_MEM, TGT_IMM, TGT_NONE} rrs_tgt_t;
  typedef enum logic {S_IDLE, S_EXEC} rrs_state_t;
endpackage

// [sim/rrs_mem_model.sv]
// Behavioural program and stack memory for the execution unit
`timescale 1ns/1ps
`default_nettype none
module rrs_mem_model
(
  // Clock
  input wire logic i_clock,
  // Memory port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_q [0:255];
  logic [7:0] last_q = 8'h00;
  // Read without a clock; an idle bus shows the inverse of the last byte
  assign o_rdata = i_rd ? mem_q[i_addr[7:0]] : ~last_q;
  // Store written bytes and remember the last byte read; the bench preloads the array
  always @(posedge i_clock)
  begin
    if (i_we)
      mem_q[i_addr[7:0]] <= i_wdata;
    if (i_rd)
      last_q <= mem_q[i_addr[7:0]];
  end
endmodule // rrs_mem_model
`default_nettype wire

// [sim/tb_rotate_return_subtract_exec.sv]
// Bench that runs every opcode from random state and checks results and cycles
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_return_subtract_exec;
  import rrs_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, chk = 1'b0;
  logic ack, rd, mwe, busy;
  logic [7:0] adr = 8'h00, mwd, mrd;
  logic [15:0] maddr;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [15:0] expq[$];
  logic [15:0] ex[6];
  int n_mismatch = 0, n_tests = 0, tick = 0;
  // Opcodes and their cycle counts, in the same order
  logic [15:0] ops[23] = '{16'h0039, 16'h0049, 16'h0059, 16'h0069, 16'h0079, 16'h9E69,
    16'h0036, 16'h0046, 16'h0056, 16'h0066, 16'h0076, 16'h9E66, 16'h009C, 16'h0080, 16'h0081,
    16'h00A2, 16'h00B2, 16'h00C2, 16'h00D2, 16'h00E2, 16'h00F2, 16'h9ED2, 16'h9EE2};
  logic [2:0] ncyc[23] = '{3'h4, 3'h1, 3'h1, 3'h4, 3'h3, 3'h5, 3'h4, 3'h1, 3'h1, 3'h4, 3'h3,
    3'h5, 3'h1, 3'h7, 3'h4, 3'h2, 3'h3, 3'h4, 3'h4, 3'h3, 3'h2, 3'h5, 3'h4};
  // Unit and its memory
  rrs_exec dut (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_we(mwe), .o_mem_rd(rd),
    .i_mem_rdata(mrd), .o_busy(busy));
  rrs_mem_model mem (.i_clock(i_clock), .i_addr(maddr), .i_wdata(mwd), .i_we(mwe),
    .i_rd(rd), .o_rdata(mrd));
  // Clock
  initial forever #25 i_clock = ~i_clock;
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic c);
    @(posedge i_clock);
    {cyc, stb, we, adr, wdat, chk} <= {2'b11, w, a, 16'h0000, d, c};
    do @(posedge i_clock); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  // Read with a noted expectation
  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    wb(1'b0, a, 16'h0000, 1'b1);
  endtask
  // Start an instruction and count the cycles that busy stands
  task automatic run(input logic [15:0] op, input logic [2:0] n);
    int k = 0;
    wb(1'b1, REG_OPCODE, op, 1'b0);
    repeat (12)
    begin
      @(posedge i_clock);
      k += int'(busy === 1'b1);
    end
    check(16'(k), 16'(n));
  endtask
  // Oldest note against acknowledged read data
  always @(posedge i_clock)
    if (ack === 1'b1 && chk === 1'b1 && we === 1'b0)
      check(rdat[15:0], expq.pop_front());
  // Closing report
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clock)
    if (++tick == 10000)
    begin
      n_mismatch++;
      give_verdict();
    end
  // Main sequence
  initial
  begin
    logic [7:0] a, x, f, fn, e, m, r, em;
    logic [15:0] p, s, o;
    logic c, v;
    void'($urandom(23175));
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    rdx(REG_SP, 16'h00FF);
    rdx(REG_FLAGS, 16'h0068);
    rdx(8'h20, 16'h0000);
    wb(1'b1, 8'h24, 16'hFFFF, 1'b0);
    repeat (3)
      for (int i = 0; i < 23; i++)
      begin
        {a, x, f, e, p} = {$urandom, $urandom};
        f = f | 8'h60;
        s = 16'h0080;
        o = ops[i];
        for (int j = 0; j < 256; j++)
          mem.mem_q[j] = 8'($urandom);
        ex = '{{8'h00, a}, {8'h00, x}, s, p, {8'h00, f}, {8'h00, e}};
        for (int k = 0; k < 6; k++)
          wb(1'b1, 8'(4 * k + 4), ex[k], 1'b0);
        m = (o[7:4] == 4'h4) ? a : (o[7:4] == 4'h5) ? x : (o == 16'h00A2) ? e : mem.mem_q[e];
        fn = f;
        em = mem.mem_q[e];
        case (o[3:0])
          4'h9: {c, r} = {m, f[0]};
          4'h6: {r, c} = {f[0], m};
          4'h2: {c, r} = {1'b0, a} - {1'b0, m} - {8'h00, f[0]};
          default: {c, r} = 9'h000;
        endcase
        v = (o[3:0] == 4'h2) ? (a[7] & ~m[7] & ~r[7]) | (~a[7] & m[7] & r[7])
          : r[7] ^ c;
        if (o[3:0] inside {4'h2, 4'h6, 4'h9})
          fn = {v, f[6:3], r[7], r == 8'h00, c};
        if (o[7:4] == 4'h4 || o[3:0] == 4'h2)
          a = r;
        else if (o[7:4] == 4'h5)
          x = r;
        else if (o[3:0] inside {4'h6, 4'h9})
          em = r;
        if (o == 16'h0080)
          {fn, a, x, p} = {mem.mem_q[s + 1] | 8'h60, mem.mem_q[s + 2], mem.mem_q[s + 3],
            mem.mem_q[s + 4], mem.mem_q[s + 5]};
        if (o == 16'h0081)
          p = {mem.mem_q[s + 1], mem.mem_q[s + 2]};
        s = s + ((o == 16'h0080) ? 16'h0005 : (o == 16'h0081) ? 16'h0002 : 16'h0000);
        if (o == 16'h009C)
          s = 16'h00FF;
        run(o, ncyc[i]);
        check({8'h00, mem.mem_q[e]}, {8'h00, em});
        ex = '{{8'h00, a}, {8'h00, x}, s, p, {8'h00, fn}, {8'h00, e}};
        for (int k = 0; k < 5; k++)
          rdx(8'(4 * k + 4), ex[k]);
      end
    wb(1'b1, REG_OPCODE, 16'h009D, 1'b0);
    rdx(REG_STATUS, 16'h0402);
    give_verdict();
  end
endmodule // tb_rotate_return_subtract_exec
`default_nettype wire
